// ===== rul_params.svh
// Purpose: Constants for the relay usage and record logger
// Assumes: 25 MHz system clock
// Notes: Temperatures in whole degrees C, signed
`ifndef RUL_PARAMS_SVH
`define RUL_PARAMS_SVH
`define RUL_CLK_HZ 25000000
`define RUL_MINUTE_S 60
`define RUL_HOUR_MIN 60
`define RUL_SEL_FORCE_OFF 2'h0
`define RUL_SEL_FORCE_ON 2'h1
`define RUL_SEL_NORM_OPEN 2'h2
`define RUL_SEL_NORM_CLOSED 2'h3
`define RUL_TEMP_LOW_PRESET 16'hFFCE
`define RUL_TEMP_HIGH_PRESET 16'h0096
`define RUL_LEVEL_MIN 16'hFC19
`define RUL_LEVEL_MAX 16'h270F
`define RUL_COUNT_MAX 14'h270F
`define RUL_FRAC_MAX 6'h3B
`define RUL_ROLE_PUMP 4'h1
`endif

// ===== rul_pkg.sv
// Purpose: Types for the relay usage and record logger
// Assumes: Included constants header
// Notes: Record selector for clear commands
package rul_pkg;
    typedef enum logic [2:0] {
        REC_PROBE_HIGH,
        REC_PROBE_LOW,
        REC_EXT_HIGH,
        REC_EXT_LOW,
        REC_LEVEL_HIGH,
        REC_LEVEL_LOW,
        REC_LEVEL_BOTH,
        REC_NONE
    } rul_rec_e;
    typedef struct packed {
        logic [13:0] minutes_since_energise;
        logic [13:0] energised_hours_total;
        logic [5:0] hours_frac_min;
        logic [13:0] energise_count;
        logic [13:0] hold_extension_count;
    } rul_pump_s;
    typedef enum logic [1:0] {
        PW_MINUTES,
        PW_HOURS,
        PW_STARTS,
        PW_HOLDS
    } rul_pfield_e;
endpackage

// ===== rul_logger.sv
// Purpose: Contact conditioning, min/max logs and per-relay pump records
// Assumes: Inputs synchronous to clk_sys; sample strobes are one-cycle pulses
// Notes: Hours total carries minutes as fraction
`timescale 1ns/1ps
`default_nettype none
`include "rul_params.svh"
// Function
// - Selector: 0 forces zero, 1 forces one, 2 closed gives one, 3 open gives one.
// - Conditioned contact value refreshes every cycle, even in programming mode.
// - Asserted conditioned value is exported as a level override event.
// - Temperature maxima start at minus fifty and rise with higher samples.
// - Temperature minima start at one hundred fifty and fall with lower samples.
// - Missing sensor at power-up reports minus fifty degrees.
// - Level high and low logs kept, clamped to minus 999 to 9999.
// - Clear command returns the selected record to its preset.
// - Per relay, minutes since last energised, zero to 9999.
// - Minutes counter clears when relay becomes energised.
// - Per relay energised hours total with minute fraction, readable and loadable.
// - Per relay start counter increments on each energise transition.
// - Per relay count of run-on hold extensions.
// - Write from operating side loads the pump record, zero included.
// - Pump records maintained only while relay role selects pump control.
module rul_logger #(
    parameter int NUM_RELAYS = 6,
    parameter int MINUTE_CYCLES = `RUL_CLK_HZ * `RUL_MINUTE_S
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic contact_input_pin,
    input wire logic [1:0] contact_input_interpretation,
    input wire logic probe_present,
    input wire logic probe_sample_valid,
    input wire logic signed [15:0] probe_temp,
    input wire logic ext_present,
    input wire logic ext_sample_valid,
    input wire logic signed [15:0] ext_temp,
    input wire logic level_sample_valid,
    input wire logic signed [15:0] level_reading,
    input wire logic clear_valid,
    input wire rul_pkg::rul_rec_e clear_select,
    input wire logic [NUM_RELAYS-1:0] relay_energised,
    input wire logic [NUM_RELAYS-1:0] hold_extension_event,
    input wire logic [4*NUM_RELAYS-1:0] relay_role_select,
    input wire logic pump_write_valid,
    input wire logic [$clog2(NUM_RELAYS)-1:0] pump_write_relay,
    input wire rul_pkg::rul_pfield_e pump_write_field,
    input wire logic [13:0] pump_write_data,
    output logic conditioned_contact_value,
    output logic level_override_event,
    output logic signed [15:0] probe_temp_value,
    output logic signed [15:0] external_temp_value,
    output logic signed [15:0] probe_temp_high_log,
    output logic signed [15:0] probe_temp_low_log,
    output logic signed [15:0] external_temp_high_log,
    output logic signed [15:0] external_temp_low_log,
    output logic signed [15:0] level_high_log,
    output logic signed [15:0] level_low_log,
    output rul_pkg::rul_pump_s [NUM_RELAYS-1:0] pump_records
);
    typedef struct packed {
        logic contact;
        logic override_evt;
        logic signed [15:0] probe_val;
        logic signed [15:0] ext_val;
        logic signed [15:0] probe_hi;
        logic signed [15:0] probe_lo;
        logic signed [15:0] ext_hi;
        logic signed [15:0] ext_lo;
        logic signed [15:0] lvl_hi;
        logic signed [15:0] lvl_lo;
        logic [31:0] minute_div;
        logic [NUM_RELAYS-1:0] prev_on;
        rul_pkg::rul_pump_s [NUM_RELAYS-1:0] pump;
    } rul_state_s;

    rul_state_s st;
    rul_state_s next_st;

    function automatic logic [13:0] sat_inc(input logic [13:0] v);
        sat_inc = (v >= `RUL_COUNT_MAX) ? `RUL_COUNT_MAX : v + 14'h0001;
    endfunction

    function automatic logic signed [15:0] lvl_clamp(input logic signed [15:0] v);
        if (v < $signed(`RUL_LEVEL_MIN)) begin
            lvl_clamp = `RUL_LEVEL_MIN;
        end else if (v > $signed(`RUL_LEVEL_MAX)) begin
            lvl_clamp = `RUL_LEVEL_MAX;
        end else begin
            lvl_clamp = v;
        end
    endfunction

    logic minute_tick;
    logic signed [15:0] lvl_c;
    assign minute_tick = (st.minute_div == 32'(MINUTE_CYCLES - 1));
    assign lvl_c = lvl_clamp(level_reading);

    always_comb begin
        next_st = st;
        // Contact conditioning runs regardless of any programming state
        case (contact_input_interpretation)
            `RUL_SEL_FORCE_OFF: next_st.contact = 1'b0;
            `RUL_SEL_FORCE_ON: next_st.contact = 1'b1;
            `RUL_SEL_NORM_OPEN: next_st.contact = contact_input_pin;
            `RUL_SEL_NORM_CLOSED: next_st.contact = ~contact_input_pin;
            default: next_st.contact = contact_input_pin;
        endcase
        next_st.override_evt = next_st.contact;
        // Absent sensor reads as the low preset
        next_st.probe_val = probe_present ? probe_temp : `RUL_TEMP_LOW_PRESET;
        next_st.ext_val = ext_present ? ext_temp : `RUL_TEMP_LOW_PRESET;
        if (probe_present && probe_sample_valid) begin
            if (probe_temp > st.probe_hi) next_st.probe_hi = probe_temp;
            if (probe_temp < st.probe_lo) next_st.probe_lo = probe_temp;
        end
        if (ext_present && ext_sample_valid) begin
            if (ext_temp > st.ext_hi) next_st.ext_hi = ext_temp;
            if (ext_temp < st.ext_lo) next_st.ext_lo = ext_temp;
        end
        if (level_sample_valid) begin
            if (lvl_c > st.lvl_hi) next_st.lvl_hi = lvl_c;
            if (lvl_c < st.lvl_lo) next_st.lvl_lo = lvl_c;
        end
        // Clear wins over a sample in the same cycle
        if (clear_valid) begin
            case (clear_select)
                rul_pkg::REC_PROBE_HIGH: next_st.probe_hi = `RUL_TEMP_LOW_PRESET;
                rul_pkg::REC_PROBE_LOW: next_st.probe_lo = `RUL_TEMP_HIGH_PRESET;
                rul_pkg::REC_EXT_HIGH: next_st.ext_hi = `RUL_TEMP_LOW_PRESET;
                rul_pkg::REC_EXT_LOW: next_st.ext_lo = `RUL_TEMP_HIGH_PRESET;
                rul_pkg::REC_LEVEL_HIGH: next_st.lvl_hi = `RUL_LEVEL_MIN;
                rul_pkg::REC_LEVEL_LOW: next_st.lvl_lo = `RUL_LEVEL_MAX;
                rul_pkg::REC_LEVEL_BOTH: begin
                    next_st.lvl_hi = `RUL_LEVEL_MIN;
                    next_st.lvl_lo = `RUL_LEVEL_MAX;
                end
                default: ;
            endcase
        end
        next_st.minute_div = minute_tick ? 32'h0 : st.minute_div + 32'h1;
        next_st.prev_on = relay_energised;
        for (int i = 0; i < NUM_RELAYS; i++) begin
            if (relay_role_select[4*i +: 4] == `RUL_ROLE_PUMP) begin
                if (relay_energised[i] && !st.prev_on[i]) begin
                    next_st.pump[i].minutes_since_energise = 14'h0;
                    next_st.pump[i].energise_count = sat_inc(st.pump[i].energise_count);
                end else if (minute_tick) begin
                    next_st.pump[i].minutes_since_energise =
                        sat_inc(st.pump[i].minutes_since_energise);
                end
                if (minute_tick && relay_energised[i]) begin
                    if (st.pump[i].hours_frac_min == `RUL_FRAC_MAX) begin
                        if (st.pump[i].energised_hours_total < `RUL_COUNT_MAX) begin
                            next_st.pump[i].hours_frac_min = 6'h0;
                            next_st.pump[i].energised_hours_total =
                                st.pump[i].energised_hours_total + 14'h0001;
                        end
                    end else begin
                        next_st.pump[i].hours_frac_min = st.pump[i].hours_frac_min + 6'h01;
                    end
                end
                if (hold_extension_event[i]) begin
                    next_st.pump[i].hold_extension_count =
                        sat_inc(st.pump[i].hold_extension_count);
                end
                // Operator write overrides any same-cycle count
                if (pump_write_valid && (32'(pump_write_relay) == i)) begin
                    case (pump_write_field)
                        rul_pkg::PW_MINUTES: next_st.pump[i].minutes_since_energise =
                            (pump_write_data > `RUL_COUNT_MAX) ? `RUL_COUNT_MAX : pump_write_data;
                        rul_pkg::PW_HOURS: begin
                            next_st.pump[i].energised_hours_total =
                                (pump_write_data > `RUL_COUNT_MAX) ? `RUL_COUNT_MAX
                                                                  : pump_write_data;
                            next_st.pump[i].hours_frac_min = 6'h0;
                        end
                        rul_pkg::PW_STARTS: next_st.pump[i].energise_count =
                            (pump_write_data > `RUL_COUNT_MAX) ? `RUL_COUNT_MAX : pump_write_data;
                        rul_pkg::PW_HOLDS: next_st.pump[i].hold_extension_count =
                            (pump_write_data > `RUL_COUNT_MAX) ? `RUL_COUNT_MAX : pump_write_data;
                        default: ;
                    endcase
                end
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st <= '0;
            st.probe_val <= `RUL_TEMP_LOW_PRESET;
            st.ext_val <= `RUL_TEMP_LOW_PRESET;
            st.probe_hi <= `RUL_TEMP_LOW_PRESET;
            st.probe_lo <= `RUL_TEMP_HIGH_PRESET;
            st.ext_hi <= `RUL_TEMP_LOW_PRESET;
            st.ext_lo <= `RUL_TEMP_HIGH_PRESET;
            st.lvl_hi <= `RUL_LEVEL_MIN;
            st.lvl_lo <= `RUL_LEVEL_MAX;
        end else begin
            st <= next_st;
        end
    end

    assign conditioned_contact_value = st.contact;
    assign level_override_event = st.override_evt;
    assign probe_temp_value = st.probe_val;
    assign external_temp_value = st.ext_val;
    assign probe_temp_high_log = st.probe_hi;
    assign probe_temp_low_log = st.probe_lo;
    assign external_temp_high_log = st.ext_hi;
    assign external_temp_low_log = st.ext_lo;
    assign level_high_log = st.lvl_hi;
    assign level_low_log = st.lvl_lo;
    assign pump_records = st.pump;
endmodule
`default_nettype wire

// ===== rul_pump_model.sv
// Purpose: Relay-driven pump stand-in for the logger bench
// Assumes: Bench commands run and run-on requests per relay
// Notes: Contactor follows its command one clock later
`timescale 1ns/1ps
`default_nettype none
module rul_pump_model (
    input wire logic clk_sys,
    input wire logic [1:0] run_cmd,
    input wire logic [1:0] hold_cmd,
    output var logic [1:0] relay_energised = 2'h0,
    output var logic [1:0] hold_extension_event = 2'h0
);
    always @(posedge clk_sys) begin
        relay_energised <= run_cmd;
        // Run-on hold only while the pump runs
        hold_extension_event <= hold_cmd & run_cmd;
    end
endmodule
`default_nettype wire

// ===== rul_logger_monitor.sv
// Purpose: Concurrent checks on contact and probe logging paths
// Assumes: Bound to every rul_logger instance
// Notes: Presets come from the shared constants header
`timescale 1ns/1ps
`default_nettype none
`include "rul_params.svh"
module rul_logger_monitor (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic contact_input_pin,
    input wire logic [1:0] contact_input_interpretation,
    input wire logic probe_present,
    input wire logic probe_sample_valid,
    input wire logic signed [15:0] probe_temp,
    input wire logic clear_valid,
    input wire rul_pkg::rul_rec_e clear_select,
    input wire logic conditioned_contact_value,
    input wire logic level_override_event,
    input wire logic signed [15:0] probe_temp_value,
    input wire logic signed [15:0] probe_temp_high_log,
    input wire logic signed [15:0] probe_temp_low_log
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence s_take;
        probe_sample_valid && probe_present && !clear_valid;
    endsequence
    chk_contact_map: assert property (!$past(rst) |-> conditioned_contact_value ==
        ($past(contact_input_interpretation[1]) ? $past(contact_input_pin ^
        contact_input_interpretation[0]) : $past(contact_input_interpretation[0])))
        else $error("contact value differs from selector mapping");
    chk_override_eq: assert property (level_override_event == conditioned_contact_value)
        else $error("override event differs from contact value");
    chk_high_raise: assert property (s_take ##0 probe_temp > probe_temp_high_log
        |=> probe_temp_high_log == $past(probe_temp)) else $error("high log not raised");
    chk_high_keep: assert property (!clear_valid |=>
        probe_temp_high_log >= $past(probe_temp_high_log)) else $error("high log fell");
    chk_low_fall: assert property (s_take ##0 probe_temp < probe_temp_low_log
        |=> probe_temp_low_log == $past(probe_temp)) else $error("low log not lowered");
    chk_clear_high: assert property (clear_valid && clear_select == rul_pkg::REC_PROBE_HIGH
        |=> probe_temp_high_log == `RUL_TEMP_LOW_PRESET) else $error("high log not cleared");
    chk_clear_low: assert property (clear_valid && clear_select == rul_pkg::REC_PROBE_LOW
        |=> probe_temp_low_log == `RUL_TEMP_HIGH_PRESET) else $error("low log not cleared");
    chk_absent_temp: assert property (!probe_present
        |=> probe_temp_value == `RUL_TEMP_LOW_PRESET) else $error("absent probe not -50");
endmodule
bind rul_logger rul_logger_monitor rul_logger_monitor_inst (.*);
`default_nettype wire

// ===== test_relay_usage_and_record_logger.sv
// Purpose: Random self-checking bench with a cycle reference model
// Assumes: Two relays, ten-cycle minute divider
// Notes: Minute divider, minutes, hours and fraction modelled from reset
`timescale 1ns/1ps
`default_nettype none
`include "rul_params.svh"
module test_relay_usage_and_record_logger;
    logic clk_sys = 1'b0, rst = 1'b1, contact_input_pin = 1'b0, probe_present = 1'b0;
    logic probe_sample_valid = 1'b0, ext_present = 1'b0, ext_sample_valid = 1'b0;
    logic level_sample_valid = 1'b0, clear_valid = 1'b0, pump_write_valid = 1'b0;
    logic conditioned_contact_value, level_override_event, exp_c;
    logic [1:0] contact_input_interpretation = 2'h0, run_cmd = 2'h0, hold_cmd = 2'h0;
    logic [1:0] relay_energised, hold_extension_event;
    logic [0:0] pump_write_relay = 1'h0;
    logic [7:0] relay_role_select = 8'h11;
    logic [13:0] pump_write_data = 14'h0;
    logic signed [15:0] probe_temp = 16'h0, ext_temp = 16'h0, level_reading = 16'h0;
    logic signed [15:0] probe_temp_value, external_temp_value, probe_temp_high_log;
    logic signed [15:0] probe_temp_low_log, external_temp_high_log, external_temp_low_log;
    logic signed [15:0] level_high_log, level_low_log;
    rul_pkg::rul_rec_e clear_select = rul_pkg::REC_NONE;
    rul_pkg::rul_pfield_e pump_write_field = rul_pkg::PW_STARTS;
    rul_pkg::rul_pump_s [1:0] pump_records;
    int err_total = 0, comparisons = 0;
    localparam int MIN_CYC = 10;
    int ph[3], pl[3], hi[3], lo[3], tv[2], starts[2], holds[2], prev_en[2], mins[2];
    int hrs[2], frac[2], div = 0;
    rul_logger #(.NUM_RELAYS(2), .MINUTE_CYCLES(MIN_CYC)) rul_logger_inst (.*);
    rul_pump_model rul_pump_model_inst (.*);
    always #20 clk_sys = !clk_sys;
    function automatic int sat(int x);
        return x > `RUL_COUNT_MAX ? `RUL_COUNT_MAX : x;
    endfunction
    task automatic cmp_val(string name, int exp, logic signed [15:0] got);
        comparisons++;
        if (got !== 16'(exp)) begin
            err_total++;
            $display("mismatch %s expected %0d seen %0d", name, exp, got);
        end
    endtask
    task automatic cmp_bit(string name, logic exp, logic got);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %b seen %b", name, exp, got);
        end
    endtask
    task automatic step_model();
        int t[3];
        logic v[3];
        logic tbl[4];
        logic pump, rise, tick;
        tbl = '{1'b0, 1'b1, contact_input_pin, !contact_input_pin};
        exp_c = tbl[contact_input_interpretation];
        t = '{probe_temp, ext_temp, level_reading};
        if (level_reading < $signed(`RUL_LEVEL_MIN)) t[2] = $signed(`RUL_LEVEL_MIN);
        if (level_reading > $signed(`RUL_LEVEL_MAX)) t[2] = `RUL_LEVEL_MAX;
        v = '{probe_sample_valid && probe_present, ext_sample_valid && ext_present,
            level_sample_valid};
        // Present sensor value follows its input every cycle
        tv[0] = probe_present ? probe_temp : ph[0];
        tv[1] = ext_present ? ext_temp : ph[0];
        for (int k = 0; k < 3; k++) begin
            if (v[k] && t[k] > hi[k]) hi[k] = t[k];
            if (v[k] && t[k] < lo[k]) lo[k] = t[k];
            if (clear_valid && (clear_select == 2 * k || (k == 2 && clear_select == 6)))
                hi[k] = ph[k];
            if (clear_valid && (clear_select == 2 * k + 1 || (k == 2 && clear_select == 6)))
                lo[k] = pl[k];
        end
        // Free running minute divider, counted from reset release
        tick = div == MIN_CYC - 1;
        div = tick ? 0 : div + 1;
        for (int r = 0; r < 2; r++) begin
            pump = relay_role_select[4*r +: 4] == `RUL_ROLE_PUMP;
            rise = relay_energised[r] && !prev_en[r];
            if (pump && rise) mins[r] = 0;
            else if (pump && tick) mins[r] = sat(mins[r] + 1);
            if (pump && rise) starts[r] = sat(starts[r] + 1);
            if (pump && hold_extension_event[r]) holds[r] = sat(holds[r] + 1);
            if (pump && tick && relay_energised[r]) begin
                if (frac[r] < `RUL_HOUR_MIN - 1) begin
                    frac[r]++;
                end else if (hrs[r] < `RUL_COUNT_MAX) begin
                    frac[r] = 0;
                    hrs[r]++;
                end
            end
            if (pump && pump_write_valid && pump_write_relay == r) begin
                if (pump_write_field == rul_pkg::PW_MINUTES) mins[r] = sat(pump_write_data);
                if (pump_write_field == rul_pkg::PW_HOURS) begin
                    hrs[r] = sat(pump_write_data);
                    frac[r] = 0;
                end
                if (pump_write_field == rul_pkg::PW_STARTS) starts[r] = sat(pump_write_data);
                if (pump_write_field == rul_pkg::PW_HOLDS) holds[r] = sat(pump_write_data);
            end
            prev_en[r] = relay_energised[r];
        end
    endtask
    task automatic drive(int n);
        contact_input_pin <= 1'($urandom);
        contact_input_interpretation <= 2'($urandom);
        probe_present <= n > 40;
        ext_present <= n > 80;
        probe_sample_valid <= 1'($urandom);
        ext_sample_valid <= 1'($urandom);
        level_sample_valid <= 1'($urandom);
        probe_temp <= 16'($urandom_range(200) - 50);
        ext_temp <= 16'($urandom_range(200) - 50);
        level_reading <= 16'($urandom_range(12000) - 1500);
        clear_valid <= $urandom_range(7) == 0;
        clear_select <= rul_pkg::rul_rec_e'(3'($urandom));
        run_cmd <= $urandom_range(3) == 0 ? 2'($urandom) : run_cmd;
        hold_cmd <= 2'($urandom) & 2'($urandom);
        relay_role_select <= n % 500 < 400 ? 8'h11 : 8'h21;
        pump_write_valid <= $urandom_range(15) == 0;
        pump_write_relay <= 1'($urandom);
        pump_write_field <= rul_pkg::rul_pfield_e'(2'($urandom));
        pump_write_data <= $urandom_range(1) ? 14'h270E : 14'($urandom);
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #200us;
        err_total++;
        summarize();
    end
    initial begin
        void'($urandom(32'h0DE2));
        ph = '{$signed(`RUL_TEMP_LOW_PRESET), $signed(`RUL_TEMP_LOW_PRESET),
            $signed(`RUL_LEVEL_MIN)};
        pl = '{`RUL_TEMP_HIGH_PRESET, `RUL_TEMP_HIGH_PRESET, `RUL_LEVEL_MAX};
        hi = ph;
        lo = pl;
        tv = '{ph[0], ph[0]};
        starts = '{0, 0};
        holds = '{0, 0};
        prev_en = '{0, 0};
        mins = '{0, 0};
        hrs = '{0, 0};
        frac = '{0, 0};
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        for (int n = 0; n < 3000; n++) begin
            @(posedge clk_sys);
            step_model();
            drive(n);
            #1;
            cmp_bit("contact", exp_c, conditioned_contact_value);
            cmp_bit("override", exp_c, level_override_event);
            cmp_val("probe_value", tv[0], probe_temp_value);
            cmp_val("ext_value", tv[1], external_temp_value);
            cmp_val("probe_high", hi[0], probe_temp_high_log);
            cmp_val("ext_high", hi[1], external_temp_high_log);
            cmp_val("probe_low", lo[0], probe_temp_low_log);
            cmp_val("ext_low", lo[1], external_temp_low_log);
            cmp_val("level_high", hi[2], level_high_log);
            cmp_val("level_low", lo[2], level_low_log);
            for (int r = 0; r < 2; r++) begin
                cmp_val("starts", starts[r], pump_records[r].energise_count);
                cmp_val("holds", holds[r], pump_records[r].hold_extension_count);
                cmp_val("mins", mins[r], pump_records[r].minutes_since_energise);
                cmp_val("hours", hrs[r], pump_records[r].energised_hours_total);
                cmp_val("frac", frac[r], pump_records[r].hours_frac_min);
            end
        end
        summarize();
    end
endmodule
`default_nettype wire
